// ===== icra_pkg.sv
package icra_pkg;
  localparam logic [6:0] BASE_ADDR = 7'h38;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam int OP_LSB = 0;
  localparam int PORT_HI_BIT = 0;
  localparam int PORT_LO_BIT = 7;
  localparam int BE_LSB = 2;
  localparam int AHI_LSB = 0;
  localparam logic [2:0] LAST_BYTE = 3'h3;
  localparam logic [2:0] CMD_BYTES = 3'h4;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef struct packed {
    logic [1:0] port;
    logic [3:0] byteEn;
    logic [11:0] addr;
    logic [31:0] data;
  } icra_req_type;
endpackage

// ===== icra_sync.sv
`timescale 1ns/10ps
module icra_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic async,
  output logic synced
);
  logic stage1;
  logic next_stage1;
  assign next_stage1 = async;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1 <= 1'b1;
      synced <= 1'b1;
    end else begin
      stage1 <= next_stage1;
      synced <= stage1;
    end
  end
endmodule

// ===== icra_top.sv
`timescale 1ns/10ps
module icra_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [2:0] slaveAddressStrapInputs,
  output logic regWrite,
  output logic regRead,
  output icra_pkg::icra_req_type regReq,
  input wire logic [31:0] regRdata
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_RX = 5'b00100,
    ST_TX = 5'b01000,
    ST_ACK = 5'b10000
  } icra_state_type;

  logic sclS, sdaS, sclD, sdaD;
  icra_sync uSyncScl (.clk(clk), .sys_rst(sys_rst), .async(sclIn), .synced(sclS));
  icra_sync uSyncSda (.clk(clk), .sys_rst(sys_rst), .async(sdaIn), .synced(sdaS));

  logic [2:0] strap;
  logic [2:0] next_strap;
  logic [2:0] strapMeta, strapSync;
  icra_state_type state, next_state;
  logic [2:0] bitCnt, next_bitCnt;
  logic [2:0] byteCnt, next_byteCnt;
  logic [7:0] shift, next_shift;
  logic [7:0] cmd0, next_cmd0, cmd1, next_cmd1, cmd2, next_cmd2;
  logic isRead, next_isRead;
  logic inData, next_inData;
  logic ackPhaseTx, next_ackPhaseTx;
  logic masterNak, next_masterNak;
  logic [31:0] buffer, next_buffer;
  logic [1:0] txIdx, next_txIdx;
  logic sawRise, next_sawRise;
  logic [7:0] curByte, nxtByte;
  logic next_sdaOut, next_sdaOe, next_regWrite, next_regRead;
  icra_pkg::icra_req_type next_regReq;

  wire sclRise = sclS & ~sclD;
  wire sclFall = ~sclS & sclD;
  wire startCond = sclS & sclD & sdaD & ~sdaS;
  wire stopCond = sclS & sclD & ~sdaD & sdaS;

  function automatic logic [7:0] bufByte(input logic [31:0] b, input logic [1:0] i);
    bufByte = b[8'(31 - 8 * i) -: 8];
  endfunction

  assign curByte = bufByte(buffer, txIdx);
  assign nxtByte = bufByte(buffer, txIdx + 2'h1);

  always_comb begin
    next_strap = strap;
    next_state = state;
    next_bitCnt = bitCnt;
    next_byteCnt = byteCnt;
    next_shift = shift;
    next_cmd0 = cmd0;
    next_cmd1 = cmd1;
    next_cmd2 = cmd2;
    next_isRead = isRead;
    next_inData = inData;
    next_ackPhaseTx = ackPhaseTx;
    next_masterNak = masterNak;
    next_buffer = buffer;
    next_txIdx = txIdx;
    next_sawRise = sawRise;
    next_sdaOut = sdaOut;
    next_sdaOe = sdaOe;
    next_regWrite = 1'b0;
    next_regRead = 1'b0;
    next_regReq = regReq;
    if (regRead) begin
      next_buffer = regRdata;
    end
    if (startCond) begin
      next_strap = strapSync;
      next_state = ST_ADDR;
      next_bitCnt = '0;
      next_sawRise = 1'b0;
      next_sdaOe = 1'b0;
    end else if (stopCond) begin
      next_state = ST_IDLE;
      next_sdaOe = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sdaOe = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (sclRise) begin
            next_shift = {shift[6:0], sdaS};
            next_sawRise = 1'b1;
          end
          // scl fall that ends a start is not a data bit
          if (sclFall && sawRise) begin
            if (bitCnt == icra_pkg::BIT_LAST) begin
              next_bitCnt = '0;
              if (state == ST_ADDR) begin
                if (shift[7:1] == (icra_pkg::BASE_ADDR | 7'(strap))) begin
                  next_isRead = shift[0];
                  next_sdaOe = 1'b1;
                  next_sdaOut = 1'b0;
                  next_state = ST_ACK;
                  next_byteCnt = '0;
                  next_inData = 1'b0;
                  next_txIdx = '0;
                end else begin
                  next_state = ST_IDLE;
                end
              end else begin
                next_sdaOe = 1'b1;
                next_sdaOut = 1'b0;
                next_state = ST_ACK;
                if (!inData) begin
                  case (byteCnt)
                    3'h0: next_cmd0 = shift;
                    3'h1: next_cmd1 = shift;
                    3'h2: next_cmd2 = shift;
                    default: begin
                      next_regReq.port = {cmd1[icra_pkg::PORT_HI_BIT],
                                          cmd2[icra_pkg::PORT_LO_BIT]};
                      next_regReq.byteEn = cmd2[icra_pkg::BE_LSB +: 4];
                      next_regReq.addr = {cmd2[icra_pkg::AHI_LSB +: 2], shift, 2'b00};
                      next_regRead = (cmd0[icra_pkg::OP_LSB +: 3] == icra_pkg::OP_READ);
                      next_inData = 1'b1;
                    end
                  endcase
                  next_byteCnt = (byteCnt == icra_pkg::LAST_BYTE) ? '0 : byteCnt + 3'h1;
                end else if (byteCnt < icra_pkg::CMD_BYTES) begin
                  next_regReq.data[8'(31 - 8 * byteCnt[1:0]) -: 8] = shift;
                  next_byteCnt = byteCnt + 3'h1;
                  if (byteCnt == icra_pkg::LAST_BYTE &&
                      cmd0[icra_pkg::OP_LSB +: 3] == icra_pkg::OP_WRITE) begin
                    next_regWrite = 1'b1;
                  end
                end
              end
            end else begin
              next_bitCnt = bitCnt + 3'h1;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            if (isRead) begin
              next_state = ST_TX;
              next_sdaOe = ~curByte[7];
              next_sdaOut = 1'b0;
              next_bitCnt = '0;
            end else begin
              next_sdaOe = 1'b0;
              next_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt == icra_pkg::BIT_LAST) begin
              next_sdaOe = 1'b0;
              next_ackPhaseTx = 1'b1;
              next_bitCnt = '0;
            end else if (ackPhaseTx) begin
              next_ackPhaseTx = 1'b0;
              if (masterNak) begin
                next_state = ST_IDLE;
              end else begin
                next_txIdx = txIdx + 2'h1;
                next_sdaOe = ~nxtByte[7];
              end
            end else begin
              next_bitCnt = bitCnt + 3'h1;
              next_sdaOe = ~curByte[3'(6 - bitCnt)];
            end
          end
          if (sclRise && ackPhaseTx) begin
            next_masterNak = sdaS;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
      strap <= '0;
      state <= ST_IDLE;
      bitCnt <= '0;
      byteCnt <= '0;
      shift <= '0;
      cmd0 <= '0;
      cmd1 <= '0;
      cmd2 <= '0;
      isRead <= 1'b0;
      inData <= 1'b0;
      ackPhaseTx <= 1'b0;
      masterNak <= 1'b0;
      buffer <= '0;
      txIdx <= '0;
      sawRise <= 1'b0;
      strapMeta <= '0;
      strapSync <= '0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      regWrite <= 1'b0;
      regRead <= 1'b0;
      regReq <= '0;
    end else begin
      sclD <= sclS;
      sdaD <= sdaS;
      strap <= next_strap;
      state <= next_state;
      bitCnt <= next_bitCnt;
      byteCnt <= next_byteCnt;
      shift <= next_shift;
      cmd0 <= next_cmd0;
      cmd1 <= next_cmd1;
      cmd2 <= next_cmd2;
      isRead <= next_isRead;
      inData <= next_inData;
      ackPhaseTx <= next_ackPhaseTx;
      masterNak <= next_masterNak;
      buffer <= next_buffer;
      txIdx <= next_txIdx;
      sawRise <= next_sawRise;
      strapMeta <= slaveAddressStrapInputs;
      strapSync <= strapMeta;
      sdaOut <= next_sdaOut;
      sdaOe <= next_sdaOe;
      regWrite <= next_regWrite;
      regRead <= next_regRead;
      regReq <= next_regReq;
    end
  end
endmodule

// ===== icra_chk_sva.sv
`timescale 1ns/10ps
module icra_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic regWrite,
  input wire logic regRead,
  input icra_pkg::icra_req_type regReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr_once;
    regWrite ##1 !regWrite;
  endsequence
  a_write_pulse: assert property (regWrite |-> s_wr_once) else $error("long write");
  a_read_pulse: assert property (regRead |=> !regRead) else $error("long read");
  a_one_kind: assert property (!(regWrite && regRead)) else $error("both pulses");
  a_word_align: assert property (regWrite |-> regReq.addr[1:0] == 2'h0) else $error("addr");
  a_pulse_low: assert property ((regWrite || regRead) |-> !sclIn) else $error("pulse");
  a_ack_low: assert property ($rose(sdaOe) |-> !sclIn) else $error("oe rise");
  a_hold_high: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe)) else $error("oe");
  a_req_stands: assert property (regWrite |=> $stable(regReq)) else $error("req");
  a_open_drain: assert property (sdaOut == 1'b0) else $error("sda high");
endmodule

// ===== icra_master.sv
`timescale 1ns/10ps
module icra_master (
  input wire logic clk,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic sdaDrv = 1'b1;
  initial sclIn = 1'b1;
  assign sdaIn = sdaDrv & ~sdaOe;
  task automatic hold();
    repeat (16) @(posedge clk);
  endtask
  task automatic bitx(input logic b, output logic r);
    sdaDrv <= b;
    hold();
    sclIn <= 1'b1;
    hold();
    r = sdaIn;
    sclIn <= 1'b0;
    hold();
  endtask
  task automatic start();
    sdaDrv <= 1'b1;
    hold();
    sclIn <= 1'b1;
    hold();
    sdaDrv <= 1'b0;
    hold();
    sclIn <= 1'b0;
    hold();
  endtask
  task automatic stop();
    sdaDrv <= 1'b0;
    hold();
    sclIn <= 1'b1;
    hold();
    sdaDrv <= 1'b1;
    hold();
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(last, r);
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclIn, sdaIn, sdaOut, sdaOe, regWrite, regRead;
  logic [2:0] strap = 3'h0;
  logic [31:0] regRdata = 32'h0;
  logic [31:0] r;
  icra_pkg::icra_req_type regReq, exp;
  int num_errors = 0, checks_done = 0, seed = 94, wrN = 0, rdN = 0, expWr = 0, expRd = 0;
  initial forever #2.5 clk = ~clk;
  icra_top icra_top_inst (.clk(clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .slaveAddressStrapInputs(strap), .regWrite(regWrite),
    .regRead(regRead), .regReq(regReq), .regRdata(regRdata));
  icra_master icra_master_inst (.clk(clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
  task automatic check(input logic [49:0] seen, input logic [49:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (regWrite === 1'b1) begin
      wrN++;
      check(regReq, exp);
    end
    if (regRead === 1'b1) begin
      rdN++;
      check(50'({regReq.port, regReq.addr}), 50'({exp.port, exp.addr}));
    end
  end
  task automatic send(input logic [7:0] d, input logic nak);
    logic [7:0] q;
    logic a;
    icra_master_inst.xfer(d, 1'b1, q, a);
    check({49'h0, a}, {49'h0, nak});
  endtask
  task automatic hdr(input logic [7:0] c0, input logic [1:0] p, input logic [3:0] be,
    input logic [9:0] a);
    exp = '{p, be, {a, 2'h0}, exp.data};
    icra_master_inst.start();
    send({7'h38 | {4'h0, strap}, 1'b0}, 1'b0);
    send(c0, 1'b0);
    send({7'h0, p[1]}, 1'b0);
    send({p[0], 1'b0, be, a[9:8]}, 1'b0);
    send(a[7:0], 1'b0);
  endtask
  task automatic wr(input logic [7:0] c0, input logic [1:0] p, input logic [3:0] be,
    input logic [9:0] a, input logic [31:0] d);
    exp.data = d;
    hdr(c0, p, be, a);
    for (int i = 3; i >= 0; i--) send(d[8 * i +: 8], 1'b0);
    icra_master_inst.stop();
    if (c0[2:0] == 3'h3)
      expWr++;
    check(50'(wrN), 50'(expWr));
  endtask
  task automatic rd(input logic [1:0] p, input logic [9:0] a, input logic rs, input int n);
    logic [7:0] q;
    logic ak;
    r = $random(seed);
    regRdata <= r;
    hdr(8'h04, p, 4'hf, a);
    expRd++;
    check(50'(rdN), 50'(expRd));
    if (!rs)
      icra_master_inst.stop();
    icra_master_inst.start();
    send({7'h38 | {4'h0, strap}, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      icra_master_inst.xfer(8'hff, i == n - 1, q, ak);
      check(50'(q), 50'(r[31 - 8 * (i % 4) -: 8]));
    end
    icra_master_inst.stop();
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    wr(8'h03, 2'h0, 4'hf, 10'h02d, 32'h12345678);
    wr(8'hfb, 2'h2, 4'h5, 10'h3ff, 32'hdeadbeef);
    wr(8'h05, 2'h1, 4'hf, 10'h001, 32'h0);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      wr(8'h03, 2'(r % 3), r[7:4], r[17:8], $random(seed));
    end
    rd(2'h1, 10'h02d, 1'b1, 6);
    rd(2'h2, 10'h300, 1'b0, 4);
    strap <= 3'h1;
    icra_master_inst.start();
    send(8'h70, 1'b1);
    icra_master_inst.stop();
    wr(8'h03, 2'h0, 4'h3, 10'h155, 32'ha5a55a5a);
    final_report();
  end
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule
bind icra_top icra_chk icra_chk_inst (.clk(clk), .sys_rst(sys_rst), .sclIn(sclIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .regWrite(regWrite), .regRead(regRead), .regReq(regReq));
